// [src/mcis_pkg.sv]
// Purpose: constants and types for the motion counter input select block
// Assumes: apb register map with one aligned 32-bit word per register
// Notes: filter, decoder and counter widths are fixed here
package mcis_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_SOURCE_CFG = 8'h00;
	localparam logic [7:0] OFS_INPUT_CFG = 8'h04;
	localparam logic [7:0] OFS_TARGET = 8'h08;
	localparam logic [7:0] OFS_AXIS_MODE = 8'h0c;
	localparam logic [7:0] OFS_POS_CNT = 8'h10;
	localparam logic [7:0] OFS_CMD_CNT = 8'h14;
	localparam logic [7:0] OFS_MECH_CNT = 8'h18;
	localparam logic [7:0] OFS_DEFL_CNT = 8'h1c;
	localparam logic [7:0] OFS_GEN_CNT = 8'h20;
	localparam logic [7:0] OFS_ERR_CAUSE = 8'h24;

	// ==========================================================
	// field positions
	localparam int POS_HOLD_BIT = 14;
	localparam int MECH_SRC_LSB = 8;
	localparam int DEFL_SRC_LSB = 10;
	localparam int GEN_SRC_LSB = 12;
	localparam int ENC_ERR_EN_BIT = 16;
	localparam int PLS_ERR_EN_BIT = 17;
	localparam int ENC_FILT_BIT = 18;
	localparam int ENC_MODE_LSB = 20;
	localparam int ENC_DIR_BIT = 22;
	localparam int ENC_DIS_BIT = 23;
	localparam int PLS_FILT_BIT = 24;
	localparam int PLS_MODE_LSB = 26;
	localparam int PLS_DIR_BIT = 28;
	localparam int ERR_ENC_BIT = 0;
	localparam int ERR_PLS_BIT = 1;

	// ==========================================================
	// reset values and counts
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_DEFL = 16'h0000;
	localparam int FILT_MIN_CYCLES = 3;
	localparam int NUM_PINS = 5;

	// ==========================================================
	// mode codes
	typedef enum logic [1:0] {
		MCIS_Q1X = 2'b00,
		MCIS_Q2X = 2'b01,
		MCIS_Q4X = 2'b10,
		MCIS_TWO_PULSE = 2'b11
	} mcis_in_mode_t;

	// one decoded count event
	typedef struct packed {
		logic up;
		logic dn;
		logic err;
	} mcis_ev_t;

endpackage

// [src/mcis_counter_unit.sv]
// Purpose: positioning and auxiliary counters with input decoding and apb registers
// Assumes: pulse generator inputs are on pclk; encoder and pulser pins are asynchronous
// Notes: apb answers with no wait states; pslverr on unmapped addresses
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps

module mcis_counter_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic axis_start,
	input wire logic out_pulse,
	input wire logic out_dir_down,
	input wire logic override2_active,
	input wire logic position_start_input,
	input wire logic encoder_phase_a,
	input wire logic encoder_phase_b,
	input wire logic encoder_index,
	input wire logic manual_pulser_a,
	input wire logic manual_pulser_b,
	output logic encoder_index_valid,
	output logic position_count_zero
);

	// ==========================================================
	// registers
	logic [31:0] counter_source_config;
	logic [31:0] encoder_input_config;
	logic [31:0] target_position_value;
	logic [31:0] axis_mode;
	logic [31:0] pos_cnt;
	logic [31:0] cmd_cnt;
	logic [31:0] mech_cnt;
	logic [15:0] defl_cnt;
	logic [31:0] gen_cnt;
	logic [1:0] err_cause;

	// ==========================================================
	// pin synchronisers and glitch filters
	localparam int NUM_PINS = mcis_pkg::NUM_PINS;
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] pin_s1;
	logic [NUM_PINS-1:0] pin_s2;
	logic [NUM_PINS-1:0] pin_f;
	logic [NUM_PINS-1:0] pin_filt_en;
	logic pcs_s1;
	logic pcs_s2;

	assign pin_raw = {manual_pulser_b, manual_pulser_a, encoder_index, encoder_phase_b,
		encoder_phase_a};
	// encoder phases and index share one filter bit, pulser phases the other
	assign pin_filt_en = {{2{encoder_input_config[mcis_pkg::PLS_FILT_BIT]}},
		{3{encoder_input_config[mcis_pkg::ENC_FILT_BIT]}}};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			logic [1:0] stable_cnt;

			// two flops first; the filter only ever reads the second
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
				end
			end

			// a new level is taken only after it stood 3 clocks, so shorter pulses vanish
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_f[gi] <= 1'b0;
					stable_cnt <= 2'd0;
				end else if (pin_s2[gi] == pin_f[gi]) begin
					stable_cnt <= 2'd0;
				end else if (!pin_filt_en[gi] ||
					stable_cnt == 2'(mcis_pkg::FILT_MIN_CYCLES - 1)) begin
					pin_f[gi] <= pin_s2[gi];
					stable_cnt <= 2'd0;
				end else begin
					stable_cnt <= stable_cnt + 2'd1;
				end
			end
		end
	endgenerate

	// position start pin is a level from outside the clock domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcs_s1 <= 1'b0;
			pcs_s2 <= 1'b0;
		end else begin
			pcs_s1 <= position_start_input;
			pcs_s2 <= pcs_s1;
		end
	end

	// ==========================================================
	// phase decoding
	function automatic mcis_pkg::mcis_ev_t decode(input logic [1:0] mode, input logic swap,
		input logic pa, input logic pb, input logic na, input logic nb);
		mcis_pkg::mcis_ev_t ev;
		logic oa;
		logic ob;
		logic xa;
		logic xb;
		logic ch_a;
		logic ch_b;
		ev = '0;
		// swapping the phases reverses the count direction
		oa = swap ? pb : pa;
		ob = swap ? pa : pb;
		xa = swap ? nb : na;
		xb = swap ? na : nb;
		ch_a = oa ^ xa;
		ch_b = ob ^ xb;
		if (ch_a && ch_b) begin
			ev.err = 1'b1;
		end else begin
			case (mode)
				mcis_pkg::MCIS_Q1X: begin
					// a rising with b low means a leads
					if (ch_a && xa) begin
						ev.up = ~xb;
						ev.dn = xb;
					end
				end
				mcis_pkg::MCIS_Q2X: begin
					if (ch_a) begin
						ev.up = xa ^ xb;
						ev.dn = ~(xa ^ xb);
					end
				end
				mcis_pkg::MCIS_Q4X: begin
					if (ch_a) begin
						ev.up = xa ^ xb;
						ev.dn = ~(xa ^ xb);
					end else if (ch_b) begin
						ev.up = ~(xa ^ xb);
						ev.dn = xa ^ xb;
					end
				end
				default: begin
					ev.up = ch_a && xa;
					ev.dn = ch_b && !xb;
				end
			endcase
		end
		return ev;
	endfunction

	logic [1:0] enc_prev;
	logic [1:0] pls_prev;
	mcis_pkg::mcis_ev_t enc_ev_raw;
	mcis_pkg::mcis_ev_t enc_ev;
	mcis_pkg::mcis_ev_t pls_ev;
	logic enc_disabled;

	assign enc_disabled = encoder_input_config[mcis_pkg::ENC_DIS_BIT];

	// previous filtered levels for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_prev <= 2'b00;
			pls_prev <= 2'b00;
		end else begin
			enc_prev <= pin_f[1:0];
			pls_prev <= pin_f[4:3];
		end
	end

	assign enc_ev_raw = decode(encoder_input_config[mcis_pkg::ENC_MODE_LSB +: 2],
		encoder_input_config[mcis_pkg::ENC_DIR_BIT], enc_prev[0], enc_prev[1], pin_f[0], pin_f[1]);
	// encoder events pass only while the encoder is enabled
	assign enc_ev = enc_disabled ? '0 : enc_ev_raw;
	// pulser decoding already multiplies, so counters see the decoded stream
	assign pls_ev = decode(encoder_input_config[mcis_pkg::PLS_MODE_LSB +: 2],
		encoder_input_config[mcis_pkg::PLS_DIR_BIT], pls_prev[0], pls_prev[1],
		pin_f[3], pin_f[4]);

	// index is reported valid only while the encoder is enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			encoder_index_valid <= 1'b0;
		end else begin
			encoder_index_valid <= pin_f[2] & ~enc_disabled;
		end
	end

	// ==========================================================
	// count sources as signed steps
	logic [1:0] step_out;
	logic [1:0] step_enc;
	logic [1:0] step_pls;
	logic [1:0] step_clk;
	logic clk_half;

	assign step_out = !out_pulse ? 2'b00 : (out_dir_down ? 2'b11 : 2'b01);
	assign step_enc = enc_ev.up ? 2'b01 : (enc_ev.dn ? 2'b11 : 2'b00);
	assign step_pls = pls_ev.up ? 2'b01 : (pls_ev.dn ? 2'b11 : 2'b00);
	assign step_clk = clk_half ? 2'b01 : 2'b00;

	// toggles every clock, giving one count per two reference clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_half <= 1'b0;
		end else begin
			clk_half <= ~clk_half;
		end
	end

	logic [1:0] mech_step;
	logic [1:0] gen_step;
	logic [1:0] defl_first;
	logic [1:0] defl_second;

	// source multiplexers
	always_comb begin
		case (counter_source_config[mcis_pkg::MECH_SRC_LSB +: 2])
			2'b00: mech_step = step_enc;
			2'b01: mech_step = step_out;
			2'b10: mech_step = step_pls;
			default: mech_step = 2'b00;
		endcase
		case (counter_source_config[mcis_pkg::GEN_SRC_LSB +: 2])
			2'b00: gen_step = step_out;
			2'b01: gen_step = step_enc;
			2'b10: gen_step = step_pls;
			default: gen_step = step_clk;
		endcase
		case (counter_source_config[mcis_pkg::DEFL_SRC_LSB +: 2])
			2'b00: begin
				defl_first = step_out;
				defl_second = step_enc;
			end
			2'b01: begin
				defl_first = step_out;
				defl_second = step_pls;
			end
			2'b10: begin
				defl_first = step_enc;
				defl_second = step_pls;
			end
			default: begin
				defl_first = 2'b00;
				defl_second = 2'b00;
			end
		endcase
	end

	// ==========================================================
	// counters
	logic pos_hold;
	logic [31:0] target_abs;

	assign target_abs = target_position_value[31] ? (32'h0000_0000 - target_position_value)
		: target_position_value;
	// hold only while override 2 runs and the start input is still off
	assign pos_hold = axis_mode[mcis_pkg::POS_HOLD_BIT] & override2_active & ~pcs_s2;
	assign position_count_zero = (pos_cnt == 32'h0000_0000);

	// positioning counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_cnt <= mcis_pkg::RST_WORD;
		end else if (axis_start) begin
			pos_cnt <= target_abs;
		end else if (out_pulse && !pos_hold && pos_cnt != 32'h0000_0000) begin
			pos_cnt <= pos_cnt - 32'h0000_0001;
		end
	end

	// command, mechanical and general counters, 32 bits each
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_cnt <= mcis_pkg::RST_WORD;
			mech_cnt <= mcis_pkg::RST_WORD;
			gen_cnt <= mcis_pkg::RST_WORD;
		end else begin
			cmd_cnt <= cmd_cnt + {{30{step_out[1]}}, step_out};
			mech_cnt <= mech_cnt + {{30{mech_step[1]}}, mech_step};
			gen_cnt <= gen_cnt + {{30{gen_step[1]}}, gen_step};
		end
	end

	// deflection holds the running difference of its two sources
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			defl_cnt <= mcis_pkg::RST_DEFL;
		end else begin
			defl_cnt <= defl_cnt + {{14{defl_first[1]}}, defl_first}
				- {{14{defl_second[1]}}, defl_second};
		end
	end

	// ==========================================================
	// apb slave
	logic acc;
	logic wr;
	logic rd_setup;
	logic mapped;
	logic [1:0] err_clear;

	assign acc = psel & penable;
	assign wr = acc & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	// reads are captured in setup, so the access phase always completes in one cycle
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	assign err_clear = (wr && paddr == mcis_pkg::OFS_ERR_CAUSE) ? pwdata[1:0] : 2'b00;

	// address decode
	always_comb begin
		if (paddr == mcis_pkg::OFS_SOURCE_CFG || paddr == mcis_pkg::OFS_INPUT_CFG
			|| paddr == mcis_pkg::OFS_TARGET || paddr == mcis_pkg::OFS_AXIS_MODE) begin
			mapped = 1'b1;
		end else if (paddr >= mcis_pkg::OFS_POS_CNT && paddr <= mcis_pkg::OFS_ERR_CAUSE
			&& paddr[1:0] == 2'b00) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_source_config <= mcis_pkg::RST_WORD;
			encoder_input_config <= mcis_pkg::RST_WORD;
			target_position_value <= mcis_pkg::RST_WORD;
			axis_mode <= mcis_pkg::RST_WORD;
		end else if (wr) begin
			if (paddr == mcis_pkg::OFS_SOURCE_CFG) begin
				counter_source_config <= pwdata;
			end else if (paddr == mcis_pkg::OFS_INPUT_CFG) begin
				encoder_input_config <= pwdata;
			end else if (paddr == mcis_pkg::OFS_TARGET) begin
				target_position_value <= pwdata;
			end else if (paddr == mcis_pkg::OFS_AXIS_MODE) begin
				axis_mode <= pwdata;
			end
		end
	end

	// error cause: a new event in the clearing cycle survives the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_cause <= 2'b00;
		end else begin
			err_cause[mcis_pkg::ERR_ENC_BIT] <= (enc_ev.err &
				encoder_input_config[mcis_pkg::ENC_ERR_EN_BIT]) |
				(err_cause[mcis_pkg::ERR_ENC_BIT] & ~err_clear[mcis_pkg::ERR_ENC_BIT]);
			err_cause[mcis_pkg::ERR_PLS_BIT] <= (pls_ev.err &
				encoder_input_config[mcis_pkg::PLS_ERR_EN_BIT]) |
				(err_cause[mcis_pkg::ERR_PLS_BIT] & ~err_clear[mcis_pkg::ERR_PLS_BIT]);
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= mcis_pkg::RST_WORD;
		end else if (rd_setup) begin
			if (paddr == mcis_pkg::OFS_SOURCE_CFG) begin
				prdata <= counter_source_config;
			end else if (paddr == mcis_pkg::OFS_INPUT_CFG) begin
				prdata <= encoder_input_config;
			end else if (paddr == mcis_pkg::OFS_TARGET) begin
				prdata <= target_position_value;
			end else if (paddr == mcis_pkg::OFS_AXIS_MODE) begin
				prdata <= axis_mode;
			end else if (paddr == mcis_pkg::OFS_POS_CNT) begin
				prdata <= pos_cnt;
			end else if (paddr == mcis_pkg::OFS_CMD_CNT) begin
				prdata <= cmd_cnt;
			end else if (paddr == mcis_pkg::OFS_MECH_CNT) begin
				prdata <= mech_cnt;
			end else if (paddr == mcis_pkg::OFS_DEFL_CNT) begin
				prdata <= {16'h0000, defl_cnt};
			end else if (paddr == mcis_pkg::OFS_GEN_CNT) begin
				prdata <= gen_cnt;
			end else if (paddr == mcis_pkg::OFS_ERR_CAUSE) begin
				prdata <= {30'h0000_0000, err_cause};
			end else begin
				prdata <= mcis_pkg::RST_WORD;
			end
		end
	end

endmodule

// [dv/mcis_counter_unit_sva.sv]
// Purpose: port checks for mcis_counter_unit
// Assumes: apb writes land at the access edge, as in the design
// Notes: positioning count is seen only through its zero flag
`timescale 1ns/100ps

module mcis_counter_unit_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic axis_start,
	input wire logic out_pulse,
	input wire logic override2_active,
	input wire logic position_start_input,
	input wire logic encoder_index,
	input wire logic encoder_index_valid,
	input wire logic position_count_zero
);
	// ==========
	// shadow fields, written on the same edge as the design
	logic [31:0] tgt;
	logic [31:0] in_cfg;
	logic hold_en;
	logic mapped;
	assign mapped = paddr <= mcis_pkg::OFS_ERR_CAUSE && paddr[1:0] == 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgt <= 32'h0;
			in_cfg <= 32'h0;
			hold_en <= 1'h0;
		end else if (psel && penable && pwrite) begin
			if (paddr == mcis_pkg::OFS_TARGET) begin
				tgt <= pwdata;
			end
			if (paddr == mcis_pkg::OFS_INPUT_CFG) begin
				in_cfg <= pwdata;
			end
			if (paddr == mcis_pkg::OFS_AXIS_MODE) begin
				hold_en <= pwdata[mcis_pkg::POS_HOLD_BIT];
			end
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========
	// assertions
	a_start_load: assert property (axis_start |=> position_count_zero == (tgt == 32'h0))
		else $error("zero flag wrong after start");
	a_zero_fall: assert property ($fell(position_count_zero) |-> $past(axis_start))
		else $error("count left zero without a start");
	a_zero_rise: assert property ($rose(position_count_zero) |-> $past(axis_start || out_pulse))
		else $error("count reached zero without a pulse");
	// the two sync flops mean three low samples before the hold is certain
	a_hold_freeze: assert property ((!position_start_input)[*3] ##0
		(hold_en && override2_active && !axis_start && !position_count_zero) |=> !position_count_zero)
		else $error("positioning count moved while held");
	a_index_pass: assert property ((!in_cfg[mcis_pkg::ENC_DIS_BIT] &&
		!in_cfg[mcis_pkg::ENC_FILT_BIT] && encoder_index)[*7] |-> encoder_index_valid)
		else $error("index not valid while enabled");
	a_index_block: assert property ((in_cfg[mcis_pkg::ENC_DIS_BIT])[*2] |-> !encoder_index_valid)
		else $error("index valid while disabled");
	a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
		else $error("error on mapped address");

	c_start: cover property (axis_start ##1 out_pulse);
	c_hold: cover property (hold_en && override2_active && out_pulse);
	c_err: cover property (pslverr);
	c_index: cover property (encoder_index_valid);
endmodule

bind mcis_counter_unit mcis_counter_unit_sva u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pslverr(pslverr), .axis_start(axis_start), .out_pulse(out_pulse),
	.override2_active(override2_active), .position_start_input(position_start_input),
	.encoder_index(encoder_index), .encoder_index_valid(encoder_index_valid),
	.position_count_zero(position_count_zero));

// [dv/mcis_pin_model.sv]
// Purpose: encoder and manual pulser stand-in
// Assumes: tasks are entered right after a rising edge of pclk
// Notes: hold per step sets speed, so fast and slow sources both exist
`timescale 1ns/100ps

module mcis_pin_model (
	input wire logic pclk,
	output logic enc_a,
	output logic enc_b,
	output logic enc_z,
	output logic pul_a,
	output logic pul_b
);
	// ==========
	// all lines idle low
	initial begin
		{enc_a, enc_b, enc_z, pul_a, pul_b} = 5'h0;
	end

	task automatic level(input int pin, input logic v);
		case (pin)
			0: enc_a <= v;
			1: enc_b <= v;
			2: enc_z <= v;
			default: pul_a <= v;
		endcase
	endtask

	// full quadrature cycles, a leading b, ending back at 00
	task automatic quad(input logic pul, input int cycles, input int hold);
		logic [1:0] seq [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
		for (int i = 0; i < 4 * cycles; i++) begin
			if (pul) begin
				{pul_a, pul_b} <= seq[i % 4];
			end else begin
				{enc_a, enc_b} <= seq[i % 4];
			end
			repeat (hold) @(posedge pclk);
		end
	endtask

	task automatic pulse(input int pin, input int width);
		level(pin, 1'b1);
		repeat (width) @(posedge pclk);
		level(pin, 1'b0);
	endtask

	// both phases flip at once: a broken source, only on command
	task automatic both(input logic pul);
		if (pul) begin
			{pul_a, pul_b} <= ~{pul_a, pul_b};
		end else begin
			{enc_a, enc_b} <= ~{enc_a, enc_b};
		end
	endtask
endmodule

// [dv/mcis_counter_unit_tb.sv]
// Purpose: self-checking bench for mcis_counter_unit
// Assumes: master and pin model move right after a rising edge
// Notes: table rows judge counters by differences, so earlier counts never matter
`timescale 1ns/100ps

module mcis_counter_unit_tb;
	typedef struct {
		logic [15:0] src;
		logic [15:0] icfg;
		int stim;
		int sel;
		int exp;
	} mcis_row_t;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic axis_start = 1'b0;
	logic out_pulse = 1'b0;
	logic out_dir_down = 1'b0;
	logic override2_active = 1'b0;
	logic position_start_input = 1'b0;
	logic [31:0] prdata, rd, v0, dv;
	logic pready, pslverr, er, enc_a, enc_b, enc_z, pul_a, pul_b, idx_ok, pos_zero;
	int miscompares = 0;
	int samples_checked = 0;
	logic [7:0] ofs [4] = '{mcis_pkg::OFS_MECH_CNT, mcis_pkg::OFS_GEN_CNT,
		mcis_pkg::OFS_DEFL_CNT, mcis_pkg::OFS_CMD_CNT};
	// source cfg, input cfg upper half, stimulus, counter, expected change
	mcis_row_t rows [21] = '{
		'{16'h0000, 16'h0000, 0, 0, 2}, '{16'h0000, 16'h0010, 0, 0, 4},
		'{16'h0000, 16'h0020, 0, 0, 8}, '{16'h0000, 16'h0040, 0, 0, -2},
		'{16'h0000, 16'h0030, 2, 0, 1}, '{16'h0000, 16'h0030, 3, 0, -1},
		'{16'h0000, 16'h0034, 1, 0, 0}, '{16'h0000, 16'h0034, 2, 0, 1},
		'{16'h0000, 16'h0080, 0, 0, 0}, '{16'h0200, 16'h0800, 4, 0, 8},
		'{16'h0200, 16'h1000, 4, 0, -2}, '{16'h0200, 16'h0d00, 5, 0, 1},
		'{16'h1000, 16'h0000, 0, 1, 2}, '{16'h2000, 16'h0400, 4, 1, 4},
		'{16'h0800, 16'h0000, 0, 2, 2}, '{16'h0400, 16'h0000, 4, 2, -2},
		'{16'h0100, 16'h0000, 6, 0, 3}, '{16'h0000, 16'h0000, 6, 1, 3},
		'{16'h0000, 16'h0000, 0, 2, -2}, '{16'h0000, 16'h0000, 7, 3, -3},
		'{16'h0000, 16'h0070, 3, 0, 1}};

	mcis_counter_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .axis_start(axis_start), .out_pulse(out_pulse),
		.out_dir_down(out_dir_down), .override2_active(override2_active),
		.position_start_input(position_start_input), .encoder_phase_a(enc_a),
		.encoder_phase_b(enc_b), .encoder_index(enc_z), .manual_pulser_a(pul_a),
		.manual_pulser_b(pul_b), .encoder_index_valid(idx_ok), .position_count_zero(pos_zero));
	mcis_pin_model u_pins (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
		.pul_a(pul_a), .pul_b(pul_b));

	always #5 pclk = ~pclk;

	// ==========
	// reporting
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========
	// apb master; psel stays up so a second call chains without idle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) begin
			miscompares++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
	endtask

	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		idle();
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		idle();
		check(what, rd, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic stim(input int s);
		case (s)
			0: u_pins.quad(1'b0, 2, 3);
			1: u_pins.pulse(0, 2);
			2: u_pins.pulse(0, 4);
			3: u_pins.pulse(1, 4);
			4: u_pins.quad(1'b1, 2, 6);
			6, 7: begin
				// three output pulses; code 7 counts them down
				out_dir_down <= (s == 7);
				out_pulse <= 1'b1;
				tick(3);
				out_pulse <= 1'b0;
				out_dir_down <= 1'b0;
			end
			default: u_pins.pulse(3, 4);
		endcase
		tick(10);
	endtask

	// ==========
	// main sequence
	initial begin
		tick(16);
		presetn <= 1'b1;
		tick(1);
		foreach (rows[i]) begin
			wr(mcis_pkg::OFS_SOURCE_CFG, {16'h0000, rows[i].src});
			wr(mcis_pkg::OFS_INPUT_CFG, {rows[i].icfg, 16'h0000});
			apb(1'b0, ofs[rows[i].sel], 32'h0);
			idle();
			v0 = rd;
			stim(rows[i].stim);
			apb(1'b0, ofs[rows[i].sel], 32'h0);
			idle();
			dv = rd - v0;
			if (rows[i].sel == 2) begin
				dv = {{16{dv[15]}}, dv[15:0]};
			end
			check("row", dv, 32'(rows[i].exp));
		end
		// reset in mid-run clears configuration and counts
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		rdc("source cfg", mcis_pkg::OFS_SOURCE_CFG, 32'h0);
		rdc("mech count", mcis_pkg::OFS_MECH_CNT, 32'h0);
		// refused places and the half-clock source, read back to back
		wr(mcis_pkg::OFS_SOURCE_CFG, 32'h0000_3000);
		apb(1'b0, 8'h28, 32'h0);
		idle();
		check("unmapped err", {31'h0, er}, 32'h1);
		wr(mcis_pkg::OFS_POS_CNT, 32'h0000_0005);
		rdc("count write", mcis_pkg::OFS_POS_CNT, 32'h0);
		apb(1'b0, mcis_pkg::OFS_GEN_CNT, 32'h0);
		v0 = rd;
		apb(1'b0, mcis_pkg::OFS_GEN_CNT, 32'h0);
		idle();
		check("half clock", rd - v0, 32'h1);
		// start and output pulse on the same edge: the load wins
		apb(1'b0, mcis_pkg::OFS_CMD_CNT, 32'h0);
		idle();
		v0 = rd;
		wr(mcis_pkg::OFS_TARGET, 32'hffff_fffd);
		axis_start <= 1'b1;
		out_pulse <= 1'b1;
		tick(1);
		axis_start <= 1'b0;
		tick(2);
		out_pulse <= 1'b0;
		rdc("abs load", mcis_pkg::OFS_POS_CNT, 32'h1);
		apb(1'b0, mcis_pkg::OFS_CMD_CNT, 32'h0);
		idle();
		check("command count", rd - v0, 32'h3);
		// hold until the start input turns on
		wr(mcis_pkg::OFS_AXIS_MODE, 32'h0000_4000);
		override2_active <= 1'b1;
		out_pulse <= 1'b1;
		tick(1);
		out_pulse <= 1'b0;
		rdc("held", mcis_pkg::OFS_POS_CNT, 32'h1);
		position_start_input <= 1'b1;
		tick(4);
		out_pulse <= 1'b1;
		tick(1);
		out_pulse <= 1'b0;
		rdc("released", mcis_pkg::OFS_POS_CNT, 32'h0);
		check("zero flag", {31'h0, pos_zero}, 32'h1);
		// simultaneous phase changes, flagged only when enabled
		wr(mcis_pkg::OFS_INPUT_CFG, 32'h0003_0000);
		u_pins.both(1'b0);
		tick(8);
		rdc("enc both", mcis_pkg::OFS_ERR_CAUSE, 32'h1);
		u_pins.both(1'b1);
		tick(8);
		rdc("pulser both", mcis_pkg::OFS_ERR_CAUSE, 32'h3);
		wr(mcis_pkg::OFS_ERR_CAUSE, 32'h3);
		wr(mcis_pkg::OFS_INPUT_CFG, 32'h0);
		u_pins.both(1'b0);
		u_pins.both(1'b1);
		tick(8);
		rdc("err off", mcis_pkg::OFS_ERR_CAUSE, 32'h0);
		// index passes only while the encoder is enabled
		u_pins.level(2, 1'b1);
		tick(8);
		check("index on", {31'h0, idx_ok}, 32'h1);
		wr(mcis_pkg::OFS_INPUT_CFG, 32'h0080_0000);
		tick(2);
		check("index off", {31'h0, idx_ok}, 32'h0);
		u_pins.level(2, 1'b0);
		finish_test();
	end
endmodule
